/* File: dpt_pkg.sv */
package dpt_pkg;
	// clock figures, in kHz and ns
	localparam int SYS_CLK_KHZ = 250000;
	localparam int REF_NS = 1000000 / SYS_CLK_KHZ;
	localparam int TV_PCLK_KHZ = 27000;
	// nearest whole divisor: 9 cycles gives 27.8 MHz
	localparam int TV_PER = (SYS_CLK_KHZ + TV_PCLK_KHZ / 2) / TV_PCLK_KHZ;
	// read data passes two flip-flops before use
	localparam int SYNC_LAT = 2;
	// register port
	localparam int ADDR_W = 8;
	localparam int NREG_W = 12;
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_HTIM = 8'h04;
	localparam logic [7:0] OFS_VTIM = 8'h08;
	localparam logic [7:0] OFS_PIX = 8'h0C;
	localparam logic [7:0] OFS_GSEL = 8'h10;
	localparam logic [7:0] OFS_PSAV = 8'h14;
	localparam logic [7:0] OFS_REVD = 8'h18;
	localparam logic [7:0] OFS_RDPER = 8'h1C;
	localparam logic [7:0] OFS_RDSTR = 8'h20;
	localparam logic [7:0] OFS_WRPER = 8'h24;
	localparam logic [7:0] OFS_WRSTR = 8'h28;
	localparam logic [7:0] OFS_WDATA = 8'h2C;
	localparam logic [7:0] OFS_RDATA = 8'h30;
	localparam logic [7:0] OFS_STAT = 8'h34;
	// word index of each register
	localparam int IX_CTRL = OFS_CTRL / 4;
	localparam int IX_HTIM = OFS_HTIM / 4;
	localparam int IX_VTIM = OFS_VTIM / 4;
	localparam int IX_PIX = OFS_PIX / 4;
	localparam int IX_GSEL = OFS_GSEL / 4;
	localparam int IX_PSAV = OFS_PSAV / 4;
	localparam int IX_REVD = OFS_REVD / 4;
	localparam int IX_RDPER = OFS_RDPER / 4;
	localparam int IX_RDSTR = OFS_RDSTR / 4;
	localparam int IX_WRPER = OFS_WRPER / 4;
	localparam int IX_WRSTR = OFS_WRSTR / 4;
	localparam int IX_WDATA = OFS_WDATA / 4;
	localparam int IX_RDATA = OFS_RDATA / 4;
	localparam int IX_STAT = OFS_STAT / 4;
	// field layout: each word holds a low and a high half
	localparam int LO = 0;
	localparam int HI = 16;
	localparam int FW = 16;
	// control bits
	localparam int C_EN = 0;
	localparam int C_TV = 1;
	localparam int C_POL = 2;
	localparam int C_GO = 3;
	localparam int C_RD = 4;
	localparam logic [31:0] CTRL_MASK = 32'h0000_0007;
	// status bits
	localparam int S_BUSY = 0;
	localparam int S_ODD = 1;
	localparam int S_RDV = 2;
	localparam logic [31:0] REG_RST = 32'h0000_0000;
	typedef enum logic [0:0] {
		ACC_IDLE = 1'b0,
		ACC_RUN = 1'b1
	} dpt_acc_t;
endpackage

/* File: dpt_timing_gen.sv */
//Contract
// R1: panel latches data on pixel clock fall; clock runs continuously while active.
// R2: line sync output starts each new line.
// R3: frame sync starts each frame and covers at least one whole line sync.
// R4: TV mode sends one 8-bit Y/U/V sample per pixel clock.
// R5: TV mode maps sample bits 7..0 onto panel data lines 17..10.
// R6: TV mode pixel clock is 27 MHz within ten percent.
// R7: TV mode line sync, frame sync and data ready are active low.
// R8: TV line sync falls at each new row, low exactly one clock.
// R9: TV frame sync falls at each new field, low one clock or more.
// R10: odd field start: frame sync and line sync fall together.
// R11: even field start: frame sync falls apart from any line sync fall.
// R12: TV samples move only while line sync is high.
// R13: read period is reference period times ceil of programmed read period; code stretches a read to ceil of read point plus 3 cycles if longer.
// R14: write period is reference period times ceil of programmed write period.
// R15: strobe down and up times round up to whole half reference periods.
// R16: read data sampled at read-enable time rounded up; display drives before it.
// R17: write data leads the strobe edge and holds until period end.
// R18: serial write clock low is down minus up; high is the rest.
// R19: serial read clock low is down minus up; high is the rest.
// R20: segment start pulse and gate, power, reversal edges follow pixel delays.
// R21: settings latched before a frame or access begins.
// R22: intervals counted in reference cycles; outputs registered on exact counts.
//
// Chosen here: the plain strobed port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module dpt_timing_gen import dpt_pkg::*; #(
	parameter int DW = 18
) (
	// clock and reset
	input wire logic i_sys_clk,
	input wire logic i_resetn,
	// register port
	input wire logic [ADDR_W-1:0] i_reg_addr,
	input wire logic [31:0] i_reg_wdata,
	input wire logic i_reg_wr,
	input wire logic i_reg_rd,
	output logic [31:0] o_reg_rdata,
	// pixel source
	input wire logic [DW-1:0] i_pix_data,
	output logic o_pix_take,
	// display pins
	output logic o_pixel_clock_out,
	output logic o_line_sync_out,
	output logic o_frame_sync_out,
	output logic o_data_ready_out,
	output logic [DW-1:0] o_panel_data_line,
	// segment driver controls
	output logic o_start_pulse,
	output logic o_gate_clock_select,
	output logic o_power_save_signal,
	output logic o_polarity_reversal,
	// asynchronous access
	output logic o_acc_select,
	output logic o_acc_read,
	output logic o_acc_strobe,
	output logic [DW-1:0] o_acc_wdata,
	output logic o_acc_wdata_oe,
	input wire logic [DW-1:0] i_acc_rdata
);

	function automatic logic [15:0] ceil_cyc(input logic [15:0] t);
		ceil_cyc = 16'((32'(t) + REF_NS - 1) / REF_NS);
	endfunction

	function automatic logic [15:0] ceil_half(input logic [15:0] t);
		ceil_half = 16'((2 * 32'(t) + REF_NS - 1) / REF_NS);
	endfunction

	function automatic logic strobe_lvl(input logic [16:0] h, input logic [15:0] up,
		input logic [15:0] dn);
		strobe_lvl = !((h >= {1'b0, up}) && (h < {1'b0, dn}));
	endfunction

	logic [31:0] regs [0:NREG_W-1];
	logic [31:0] sh [0:NREG_W-1];
	logic [31:0] rd_word;
	logic [DW-1:0] rd_buf;
	logic rd_valid;

	// register decode
	wire logic [ADDR_W-3:0] idx = i_reg_addr[ADDR_W-1:2];
	wire logic aligned = (i_reg_addr[1:0] == 2'h0);
	wire logic wr_hit = i_reg_wr && aligned;
	wire logic go_wr = wr_hit && (idx == (ADDR_W-2)'(IX_CTRL)) && i_reg_wdata[C_GO];
	wire logic rdv_clr = wr_hit && (idx == (ADDR_W-2)'(IX_STAT)) && i_reg_wdata[S_RDV];

	// display settings in force this frame
	wire logic en = regs[IX_CTRL][C_EN];
	wire logic tv = sh[IX_CTRL][C_TV];
	wire logic pol_hi = !tv && sh[IX_CTRL][C_POL];
	wire logic [15:0] h_tot = sh[IX_HTIM][LO+:FW];
	wire logic [15:0] h_sync = sh[IX_HTIM][HI+:FW];
	wire logic [15:0] v_tot = sh[IX_VTIM][LO+:FW];
	wire logic [15:0] v_sync = sh[IX_VTIM][HI+:FW];
	wire logic [15:0] pix_per = sh[IX_PIX][LO+:FW];
	wire logic [15:0] h_start = sh[IX_PIX][HI+:FW];
	wire logic [15:0] gs_rise = sh[IX_GSEL][LO+:FW];
	wire logic [15:0] gs_fall = sh[IX_GSEL][HI+:FW];
	wire logic [15:0] ps_fall = sh[IX_PSAV][LO+:FW];
	wire logic [15:0] ps_rise = sh[IX_PSAV][HI+:FW];
	wire logic [15:0] rev_dly = sh[IX_REVD][LO+:FW];

	// pixel clock divider
	logic [15:0] pdiv_cnt;
	logic [15:0] h_cnt;
	logic [15:0] v_cnt;
	logic field_odd;
	wire logic [15:0] pper = tv ? 16'(TV_PER) : ((pix_per < 16'h0002) ? 16'h0002 : pix_per); // R6
	wire logic px_tick = en && (pdiv_cnt >= pper - 16'h0001);
	wire logic [15:0] next_pdiv = (px_tick || !en) ? 16'h0000 : pdiv_cnt + 16'h0001;
	wire logic next_pclk = en && (next_pdiv < (pper >> 1)); // R1

	// raster counters
	wire logic [15:0] h_last = (h_tot == 16'h0000) ? 16'h0000 : h_tot - 16'h0001;
	wire logic [15:0] v_last = (v_tot == 16'h0000) ? 16'h0000 : v_tot - 16'h0001;
	wire logic h_wrap = (h_cnt >= h_last);
	wire logic v_wrap = (v_cnt >= v_last);
	wire logic frame_wrap = px_tick && h_wrap && v_wrap;
	wire logic [15:0] next_h = h_wrap ? 16'h0000 : h_cnt + 16'h0001;
	wire logic [15:0] next_v = !h_wrap ? v_cnt : (v_wrap ? 16'h0000 : v_cnt + 16'h0001);
	wire logic next_field = tv ? !field_odd : 1'b1;

	// timing decode on the pixel now leaving
	wire logic [15:0] h_half = h_tot >> 1;
	wire logic hs_act = tv ? (h_cnt == 16'h0000) : (h_cnt < h_sync); // R2 R8
	wire logic vs_odd = (v_cnt < v_sync); // R10
	wire logic vs_even = vs_odd && !((v_cnt == 16'h0000) && (h_cnt < h_half)); // R11
	wire logic vs_act = (tv && !field_odd) ? vs_even : vs_odd; // R3 R9
	wire logic de = (v_cnt >= v_sync) && (tv ? !hs_act : (h_cnt >= h_start)); // R12
	wire logic sp_act = (h_cnt + 16'h0001 == h_start); // R20
	wire logic gs_act = (h_cnt >= gs_rise) && (h_cnt < gs_fall); // R20
	wire logic ps_lvl = !((h_cnt >= ps_fall) && (h_cnt < ps_rise)); // R20
	wire logic rev_hit = (h_cnt == rev_dly); // R20
	// TV samples ride on lines 17..10, the rest stay low
	wire logic [DW-1:0] tv_word = {i_pix_data[7:0], {(DW - 8){1'b0}}}; // R4 R5

	assign o_pix_take = px_tick && de;

	logic hs_q;
	logic vs_q;
	logic out_tv;
	logic out_odd;

	// display outputs change on a pixel tick, with the clock rising; syncs go idle at once while disabled
	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			pdiv_cnt <= 16'h0000;
			o_pixel_clock_out <= 1'b0;
			h_cnt <= 16'h0000;
			v_cnt <= 16'h0000;
			field_odd <= 1'b1;
		end else begin
			pdiv_cnt <= next_pdiv; // R22
			o_pixel_clock_out <= next_pclk; // R1
			if (!en) begin
				h_cnt <= 16'h0000;
				v_cnt <= 16'h0000;
				field_odd <= 1'b1;
			end else if (px_tick) begin
				h_cnt <= next_h;
				v_cnt <= next_v;
				if (h_wrap && v_wrap) begin
					field_odd <= next_field;
				end
			end
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			hs_q <= 1'b0;
			vs_q <= 1'b0;
			out_tv <= 1'b0;
			out_odd <= 1'b1;
			o_line_sync_out <= 1'b1;
			o_frame_sync_out <= 1'b1;
			o_data_ready_out <= 1'b1;
			o_panel_data_line <= '0;
		end else if (!en) begin
			hs_q <= 1'b0;
			vs_q <= 1'b0;
			o_line_sync_out <= !pol_hi;
			o_frame_sync_out <= !pol_hi;
			o_data_ready_out <= !pol_hi;
		end else if (px_tick) begin
			hs_q <= hs_act;
			vs_q <= vs_act;
			out_tv <= tv;
			out_odd <= field_odd;
			o_line_sync_out <= pol_hi ? hs_act : !hs_act; // R7 R22
			o_frame_sync_out <= pol_hi ? vs_act : !vs_act; // R7
			o_data_ready_out <= pol_hi ? de : !de; // R7
			o_panel_data_line <= !de ? '0 : (tv ? tv_word : i_pix_data); // R4 R12
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_start_pulse <= 1'b0;
			o_gate_clock_select <= 1'b0;
			o_power_save_signal <= 1'b1;
			o_polarity_reversal <= 1'b0;
		end else if (px_tick && !tv) begin
			o_start_pulse <= sp_act; // R20
			o_gate_clock_select <= gs_act; // R20
			o_power_save_signal <= ps_lvl; // R20
			o_polarity_reversal <= o_polarity_reversal ^ rev_hit; // R20
		end
	end

	// register file; display words reach the logic at a frame boundary, or every cycle while the display is off
	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			for (int i = 0; i < NREG_W; i++) begin
				regs[i] <= REG_RST;
				sh[i] <= REG_RST;
			end
		end else begin
			for (int i = 0; i < NREG_W; i++) begin
				if (wr_hit && (idx == (ADDR_W-2)'(i))) begin
					regs[i] <= (i == IX_CTRL) ? (i_reg_wdata & CTRL_MASK) : i_reg_wdata;
				end
				if (!en || !sh[IX_CTRL][C_EN] || frame_wrap) begin
					sh[i] <= regs[i]; // R21
				end
			end
		end
	end

	// asynchronous access engine
	dpt_acc_t acc_st;
	dpt_acc_t next_acc_st;
	logic [15:0] acc_cnt;
	logic [15:0] acc_end;
	logic [15:0] acc_per;
	logic [15:0] up_h;
	logic [15:0] dn_h;
	logic [15:0] rp_cnt;
	logic pos_lvl;
	logic neg_lvl;
	logic [DW-1:0] rd_s1;
	logic [DW-1:0] rd_s2;

	wire logic go_rd = i_reg_wdata[C_RD];
	wire logic [31:0] per_w = go_rd ? regs[IX_RDPER] : regs[IX_WRPER];
	wire logic [31:0] str_w = go_rd ? regs[IX_RDSTR] : regs[IX_WRSTR];
	wire logic [15:0] per_raw = ceil_cyc(per_w[LO+:FW]); // R13 R14
	wire logic [15:0] per_c = (per_raw == 16'h0000) ? 16'h0001 : per_raw;
	wire logic [15:0] rp_c = ceil_cyc(regs[IX_RDPER][HI+:FW]); // R16
	wire logic [15:0] rp_end = rp_c + 16'(SYNC_LAT);
	wire logic [15:0] end_c = (go_rd && (rp_end >= per_c)) ? rp_end : per_c - 16'h0001;
	wire logic [15:0] dn_c = ceil_half(str_w[LO+:FW]); // R15
	wire logic [15:0] up_c = ceil_half(str_w[HI+:FW]); // R15
	wire logic acc_start = go_wr && (acc_st == ACC_IDLE);
	wire logic acc_done = (acc_st == ACC_RUN) && (acc_cnt >= acc_end);
	wire logic [15:0] next_acc_cnt = (acc_st == ACC_RUN) ? acc_cnt + 16'h0001 : 16'h0000;
	wire logic rd_cap = (acc_st == ACC_RUN) && o_acc_read && (acc_cnt == rp_cnt + 16'(SYNC_LAT));

	always_comb begin
		next_acc_st = acc_st;
		case (acc_st)
			ACC_IDLE: begin
				if (acc_start) begin
					next_acc_st = ACC_RUN;
				end
			end
			ACC_RUN: begin
				if (acc_done) begin
					next_acc_st = ACC_IDLE;
				end
			end
			default: next_acc_st = ACC_IDLE;
		endcase
	end

	// every timing of an access is fixed from the words at its start
	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			acc_st <= ACC_IDLE;
			acc_cnt <= 16'h0000;
			acc_end <= 16'h0000;
			acc_per <= 16'h0000;
			up_h <= 16'h0000;
			dn_h <= 16'h0000;
			rp_cnt <= 16'h0000;
			o_acc_read <= 1'b0;
			o_acc_wdata <= '0;
		end else begin
			acc_st <= next_acc_st;
			acc_cnt <= acc_start ? 16'h0000 : next_acc_cnt; // R22
			if (acc_start) begin
				acc_end <= end_c; // R21
				acc_per <= per_c;
				up_h <= up_c;
				dn_h <= dn_c;
				rp_cnt <= rp_c;
				o_acc_read <= go_rd;
				o_acc_wdata <= regs[IX_WDATA][DW-1:0]; // R17
			end
		end
	end

	// strobe edges fall on either clock edge: one flop per phase
	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			pos_lvl <= 1'b1;
		end else if (acc_start) begin
			pos_lvl <= neg_lvl ^ strobe_lvl(17'h00000, up_c, dn_c); // R15
		end else if ((acc_st == ACC_RUN) && !acc_done) begin
			pos_lvl <= neg_lvl ^ strobe_lvl({next_acc_cnt, 1'b0}, up_h, dn_h); // R18 R19
		end else begin
			pos_lvl <= !neg_lvl;
		end
	end

	always_ff @(negedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			neg_lvl <= 1'b0;
		end else begin
			neg_lvl <= pos_lvl ^ ((acc_st != ACC_RUN) || strobe_lvl({acc_cnt, 1'b1}, up_h, dn_h)); // R19
		end
	end

	// xor of the phase flops keeps the clock out of the strobe path, so no glitch
	assign o_acc_strobe = pos_lvl ^ neg_lvl;
	assign o_acc_select = (acc_st == ACC_RUN);
	assign o_acc_wdata_oe = (acc_st == ACC_RUN) && !o_acc_read;

	// read data: two flops, then taken at the rounded read point
	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			rd_s1 <= '0;
			rd_s2 <= '0;
			rd_buf <= '0;
			rd_valid <= 1'b0;
		end else begin
			rd_s1 <= i_acc_rdata;
			rd_s2 <= rd_s1;
			if (rd_cap) begin
				rd_buf <= rd_s2; // R16
			end
			rd_valid <= rd_cap || (rd_valid && !rdv_clr);
		end
	end

	// read port
	wire logic [31:0] stat_word = {29'h0, rd_valid, field_odd, o_acc_select};
	always_comb begin
		rd_word = 32'h0000_0000;
		if (aligned && (idx < (ADDR_W-2)'(NREG_W))) begin
			rd_word = regs[idx[3:0]];
		end else if (aligned && (idx == (ADDR_W-2)'(IX_RDATA))) begin
			rd_word = 32'(rd_buf);
		end else if (aligned && (idx == (ADDR_W-2)'(IX_STAT))) begin
			rd_word = stat_word;
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_reg_rdata <= 32'h0000_0000;
		end else begin
			o_reg_rdata <= i_reg_rd ? rd_word : 32'h0000_0000;
		end
	end

	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (!i_resetn);

	sequence s_acc_end;
		acc_st == ACC_RUN ##1 acc_st == ACC_IDLE;
	endsequence

	a_pclk_rise_tick: assert property (px_tick |=> o_pixel_clock_out) // R1
		else $error("pixel clock not high after data update");
	a_pclk_keeps_running: assert property (en ##1 en |-> ##[1:600] $changed(o_pixel_clock_out)) // R1
		else $error("pixel clock stalled while active");
	a_frame_has_line: assert property (!out_tv && $rose(vs_q) |-> $rose(hs_q)) // R3
		else $error("frame sync starts without a line sync");
	a_hs_single_cycle: assert property (out_tv && px_tick && !o_line_sync_out |=> o_line_sync_out) // R8
		else $error("line sync low longer than one pixel");
	a_tv_no_data_gap: assert property (out_tv && !o_line_sync_out |-> o_data_ready_out) // R12
		else $error("sample sent during line sync");
	a_odd_field_align: assert property (out_tv && out_odd && $fell(o_frame_sync_out)
		|-> $fell(o_line_sync_out)) // R10
		else $error("odd field syncs do not coincide");
	a_even_field_apart: assert property (out_tv && !out_odd && $fell(o_frame_sync_out)
		|-> !$fell(o_line_sync_out)) // R11
		else $error("even field syncs coincide");
	a_access_length: assert property (s_acc_end |-> $past(acc_cnt) == acc_end
		&& acc_end >= acc_per - 16'h0001) // R13
		else $error("access period wrong");
	a_wdata_held: assert property (acc_st == ACC_RUN && $past(acc_st == ACC_RUN)
		|-> $stable(o_acc_wdata)) // R17
		else $error("write data moved inside the period");

endmodule // dpt_timing_gen
`default_nettype wire

/* File: dpt_display_model.sv */
`timescale 1ns/1ps
`default_nettype none
module dpt_display_model import dpt_pkg::*; #(
	parameter int DW = 18,
	parameter logic [17:0] RVAL = 18'h2D5A3
) (
	// clock
	input wire logic i_sys_clk,
	// access pins
	input wire logic i_slow,
	input wire logic i_acc_select,
	input wire logic i_acc_read,
	input wire logic i_acc_strobe,
	input wire logic [DW-1:0] i_acc_wdata,
	output logic [DW-1:0] o_acc_rdata,
	output logic [DW-1:0] o_wr_seen,
	// panel pins
	input wire logic i_pclk,
	input wire logic [DW-1:0] i_pdata,
	output logic [DW-1:0] o_pix_seen
);
	logic armed;
	logic [DW-1:0] junk;
	initial begin
		armed = 1'b0;
		junk = '0;
		o_wr_seen = '0;
		o_pix_seen = '0;
	end
	// released bus toggles so stale data never passes for valid
	always @(posedge i_sys_clk) begin
		junk <= ~junk;
		armed <= i_acc_select && i_acc_read && (armed || !i_acc_strobe);
	end
	// slow answer: data only once the strobe has gone low
	assign o_acc_rdata = (i_acc_select && i_acc_read && (armed || !i_slow)) ? RVAL : junk;
	always @(posedge i_acc_strobe) begin
		if (i_acc_select && !i_acc_read)
			o_wr_seen <= i_acc_wdata;
	end
	always @(negedge i_pclk) begin
		o_pix_seen <= i_pdata;
	end
endmodule // dpt_display_model
`default_nettype wire

/* File: testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench import dpt_pkg::*;;
	localparam logic [17:0] RV = 18'h2D5A3;
	logic clk = 0, rstn = 0, we = 0, re = 0, slow = 0;
	logic [7:0] addr = '0;
	logic [31:0] wd = '0, rdat;
	logic [17:0] pix = '0, pd, awd, ard, wseen, pseen;
	logic take, pclk, ls, fs, dr, stp, gs, psv, flip, sel, rdsel, stb, oe;
	int n_mismatch = 0, checks_done = 0, scnt = 0, ocnt = 0;
	real tf = 0, tl = 0, tr = 0, tp = 0;
	logic [7:0] q[$];
	dpt_timing_gen dut (.i_sys_clk(clk), .i_resetn(rstn), .i_reg_addr(addr),
		.i_reg_wdata(wd), .i_reg_wr(we), .i_reg_rd(re), .o_reg_rdata(rdat),
		.i_pix_data(pix), .o_pix_take(take), .o_pixel_clock_out(pclk),
		.o_line_sync_out(ls), .o_frame_sync_out(fs), .o_data_ready_out(dr),
		.o_panel_data_line(pd), .o_start_pulse(stp), .o_gate_clock_select(gs),
		.o_power_save_signal(psv), .o_polarity_reversal(flip), .o_acc_select(sel),
		.o_acc_read(rdsel), .o_acc_strobe(stb), .o_acc_wdata(awd),
		.o_acc_wdata_oe(oe), .i_acc_rdata(ard));
	dpt_display_model #(.RVAL(RV)) model (.i_sys_clk(clk), .i_slow(slow),
		.i_acc_select(sel), .i_acc_read(rdsel), .i_acc_strobe(stb),
		.i_acc_wdata(awd), .o_acc_rdata(ard), .o_wr_seen(wseen),
		.i_pclk(pclk), .i_pdata(pd), .o_pix_seen(pseen));
	initial begin
		forever #2 clk = ~clk;
	end
	always @(posedge clk) begin
		if (take) q.push_back(pix[7:0]);
		if (take) pix <= pix + 18'h1;
		if (sel) scnt <= scnt + 1;
		if (oe) ocnt <= ocnt + 1;
	end
	always @(negedge stb) tf = $realtime;
	always @(posedge stb) tl = $realtime - tf;
	always @(posedge pclk) begin
		tp = $realtime - tr;
		tr = $realtime;
	end
	function automatic int cdiv(input int a, input int b);
		return (a + b - 1) / b;
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wd <= d;
		we <= 1'b1;
		@(posedge clk);
		we <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk);
		addr <= a;
		re <= 1'b1;
		@(posedge clk);
		re <= 1'b0;
		#1 d = rdat;
	endtask
	// second start lands while busy and must not stretch the access
	task automatic acc(input logic [31:0] c, output int n);
		int k;
		n = scnt;
		k = 0;
		wr(OFS_CTRL, c);
		wr(OFS_CTRL, c);
		while (sel !== 1'b0 && k < 200) begin
			@(posedge clk);
			#1 k++;
		end
		n = scnt - n;
	endtask
	task automatic t_regs();
		logic [31:0] v;
		chk({pclk, ls, fs, dr, psv, stb, sel, oe}, 8'h7C);
		rd(OFS_HTIM, v);
		chk(v, REG_RST);
		wr(OFS_HTIM, 32'h0003_0008);
		wr(8'h05, 32'hFFFF_FFFF);
		rd(OFS_HTIM, v);
		chk(v, 32'h0003_0008);
		rd(8'h40, v);
		chk(v, 32'h0);
		@(posedge clk);
		#1 chk(rdat, 32'h0);
	endtask
	task automatic t_write();
		int n, o;
		wr(OFS_WRPER, 32'd12);
		wr(OFS_WRSTR, {16'd3, 16'd10});
		wr(OFS_WDATA, 32'h0002_5A3C);
		o = ocnt;
		acc(32'h8, n);
		chk(n, cdiv(12, REF_NS));
		chk(ocnt - o, cdiv(12, REF_NS));
		chk(rdsel, 1'b0);
		chk(int'(tl), (cdiv(2 * 10, REF_NS) - cdiv(2 * 3, REF_NS)) * REF_NS / 2);
		chk(wseen, 18'h25A3C);
	endtask
	task automatic t_read();
		int n, i, e;
		logic [31:0] v;
		for (i = 0; i < 2; i++) begin
			slow <= i[0];
			wr(OFS_RDPER, {16'(12 + 28 * i), 16'd20});
			wr(OFS_RDSTR, {16'd2, 16'd14});
			acc(32'h18, n);
			e = cdiv(12 + 28 * i, REF_NS) + SYNC_LAT + 1;
			if (e < cdiv(20, REF_NS)) e = cdiv(20, REF_NS);
			chk(n, e);
			chk(rdsel, 1'b1);
			chk(int'(tl), (cdiv(2 * 14, REF_NS) - cdiv(2 * 2, REF_NS)) * REF_NS / 2);
			rd(OFS_RDATA, v);
			chk(v, {14'h0, RV});
			rd(OFS_STAT, v);
			chk(v[S_RDV], 1'b1);
			wr(OFS_STAT, 32'h4);
			rd(OFS_STAT, v);
			chk(v[S_RDV], 1'b0);
		end
	endtask
	task automatic t_tv();
		int i, run, odd, even, first;
		logic pls, pfs;
		run = 0;
		odd = 0;
		even = 0;
		first = -1;
		wr(OFS_HTIM, 32'h0001_0008);
		wr(OFS_VTIM, 32'h0001_0004);
		q.delete();
		pls = ls;
		pfs = fs;
		wr(OFS_CTRL, 32'h3);
		for (i = 0; i < 80; i++) begin
			@(negedge pclk);
			#1;
			if (!dr) chk(pseen, {q.pop_front(), 10'h0});
			if (!dr) chk(ls, 1'b1);
			if (!ls) run++;
			else begin
				if (!pls) chk(run, 1);
				run = 0;
			end
			if (!fs && pfs) begin
				if (!ls && pls) odd++;
				else even++;
				if (first < 0) first = int'(!ls && pls);
			end
			pls = ls;
			pfs = fs;
		end
		chk(first, 1);
		chk(odd, 2);
		chk(even, 1);
		chk(int'(tp), TV_PER * REF_NS);
		chk(1.0e6 / tp >= 24300.0 && 1.0e6 / tp <= 29700.0, 1'b1);
		wr(OFS_CTRL, 32'h0);
	endtask
	// line position is rebuilt from the line sync rise, so no design state is read
	task automatic t_seg();
		int i, h;
		logic pls, pfs, pfl, full;
		h = -1;
		full = 1'b0;
		wr(OFS_HTIM, 32'h0002_000A);
		wr(OFS_VTIM, 32'h0001_0003);
		wr(OFS_PIX, 32'h0004_0002);
		wr(OFS_GSEL, 32'h0006_0003);
		wr(OFS_PSAV, 32'h0005_0002);
		wr(OFS_REVD, 32'h7);
		pls = ls;
		pfs = fs;
		pfl = flip;
		wr(OFS_CTRL, 32'h5);
		for (i = 0; i < 70; i++) begin
			@(negedge pclk);
			#1;
			if (ls && !pls) h = 0;
			else if (h >= 0) h++;
			if (h >= 0) begin
				chk(ls, h < 2);
				chk(stp, h == 3);
				chk(gs, h >= 3 && h < 6);
				chk(psv, !(h >= 2 && h < 5));
				chk(flip ^ pfl, h == 7);
				chk(int'(tp), 2 * REF_NS);
			end
			if (fs && !ls && pls) full = 1'b1;
			if (!fs && pfs) chk(full, 1'b1);
			if (!fs) full = 1'b0;
			pls = ls;
			pfs = fs;
			pfl = flip;
		end
		wr(OFS_CTRL, 32'h0);
	endtask
	task automatic report_and_stop();
		$display("mismatches %0d checks %0d", n_mismatch, checks_done);
		if (n_mismatch == 0 && checks_done > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial begin
		#100000;
		n_mismatch++;
		report_and_stop();
	end
	initial begin
		repeat (5) @(posedge clk);
		rstn <= 1'b1;
		t_regs();
		t_write();
		t_read();
		t_tv();
		t_seg();
		report_and_stop();
	end
endmodule // testbench
`default_nettype wire
